/* File: rtl/pxevd_regs.vh */
// Constants for the pixel event detector: event record layout,
// default identities and the background dump period.
// Assumes one clock domain and a plain Verilog-2005 tool flow.
//
// Operation
// - Compare each pixel sample with its background
// - Background is exponential average, adjustable shift
// - Only positive excess over threshold raises event
// - Threshold from 32-entry table, background-indexed
// - Each event is one 64-bit record
// - Packet id, status, zeros, consecutive status
// - Frame number, formatter unit identifier fields
// - Processor identifier and pixel index fields
// - Intensity and five background bits fields
// - Scene leaves only as event records
// - Dump averaged background every 75000 frames
// - Events queued in per-subarray FIFO
`ifndef PXEVD_REGS_VH
`define PXEVD_REGS_VH

// ********************************
// Event record field positions
// ********************************
`define PXEVD_PKT_LSB      0
`define PXEVD_STAT_LSB     3
`define PXEVD_ZERO_LSB     10
`define PXEVD_CONS_LSB     12
`define PXEVD_FRAME_LSB    14
`define PXEVD_UNIT_LSB     24
`define PXEVD_PROC_LSB     28
`define PXEVD_PIX_LSB      30
`define PXEVD_INT_LSB      45
`define PXEVD_BGB_LSB      59
`define PXEVD_REC_W        64

// ********************************
// Widths and defaults
// ********************************
`define PXEVD_SAMPLE_W     14
`define PXEVD_PIX_W        15
`define PXEVD_FRAME_W      10
`define PXEVD_THR_AW       5
`define PXEVD_SHIFT_W      4
`define PXEVD_PIX_COUNT    31850
`define PXEVD_FRAME_HZ     500
`define PXEVD_DUMP_FRAMES  75000
`define PXEVD_PKT_ID       3'h1
`define PXEVD_UNIT_ID      4'h0
`define PXEVD_PROC_ID      2'h0
`define PXEVD_FIFO_AW      4
`define PXEVD_BG_MAX       14'h3fff

`endif

/* File: rtl/pxevd_ram.v */
// Simple dual-port memory, one write port, one read port.
// Read data come out of a register one cycle after the address.
// Contents are not reset; users load or overwrite before reading.
`timescale 1ns/1ps
module pxevd_ram #(
    parameter DW = 16,
    parameter AW = 15
) (
    // Clock
    input  wire          clk,
    // Write port
    input  wire          we,
    input  wire [AW-1:0] waddr,
    input  wire [DW-1:0] wdata,
    // Read port
    input  wire [AW-1:0] raddr,
    output reg  [DW-1:0] rdata
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    always @(posedge clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule

/* File: rtl/pxevd_top.v */
// Pixel event detector: background averaging, threshold lookup,
// event record formatting, event queue and background dump.
// Assumes the video stream comes from logic on REF_CLK, one pixel
// per valid cycle, each pixel at most once per frame.
`timescale 1ns/1ps
`include "pxevd_regs.vh"
module pxevd_top #(
    parameter DUMP_FRAMES = `PXEVD_DUMP_FRAMES,
    parameter FIFO_AW     = `PXEVD_FIFO_AW,
    parameter [2:0] PKT_ID  = `PXEVD_PKT_ID,
    parameter [3:0] UNIT_ID = `PXEVD_UNIT_ID,
    parameter [1:0] PROC_ID = `PXEVD_PROC_ID
) (
    // Clock and reset
    input  wire                          REF_CLK,
    input  wire                          RST,
    // Video stream in
    input  wire                          FRAME_START,
    input  wire                          PIX_VALID,
    input  wire [`PXEVD_PIX_W-1:0]       PIX_INDEX,
    input  wire [`PXEVD_SAMPLE_W-1:0]    PIX_DATA,
    // Settings
    input  wire [`PXEVD_SHIFT_W-1:0]     BG_SHIFT,
    input  wire                          THR_WR,
    input  wire [`PXEVD_THR_AW-1:0]      THR_ADDR,
    input  wire [`PXEVD_SAMPLE_W-1:0]    THR_DATA,
    // Event record stream out
    output reg                           EVT_VALID,
    input  wire                          EVT_READY,
    output reg  [`PXEVD_REC_W-1:0]       EVT_DATA,
    output reg                           EVT_DROPPED,
    // Background image out
    output reg                           BG_VALID,
    output reg  [`PXEVD_PIX_W-1:0]       BG_INDEX,
    output reg  [`PXEVD_SAMPLE_W-1:0]    BG_DATA
);
    localparam SW  = `PXEVD_SAMPLE_W;
    localparam PW  = `PXEVD_PIX_W;
    localparam FW  = `PXEVD_FRAME_W;
    localparam MW  = SW + 2;
    localparam FD  = 1 << FIFO_AW;

    // ********************************
    // Frame number and dump schedule
    // ********************************
    reg  [FW-1:0] frame_reg;
    reg  [16:0]   dump_cnt_reg;
    reg           dump_reg;

    always @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            frame_reg    <= {FW{1'b0}};
            dump_cnt_reg <= 17'h0;
            dump_reg     <= 1'b0;
        end
        else if (FRAME_START)
        begin
            frame_reg <= frame_reg + 1'b1;
            if (dump_cnt_reg == DUMP_FRAMES[16:0] - 17'h1)
            begin
                dump_cnt_reg <= 17'h0;
                dump_reg     <= 1'b1;
            end
            else
            begin
                dump_cnt_reg <= dump_cnt_reg + 17'h1;
                dump_reg     <= 1'b0;
            end
        end
    end

    // ********************************
    // Stage 1: background memory read
    // ********************************
    // Memory word: {consecutive count, background}
    wire [MW-1:0] bg_rdata;
    wire [SW-1:0] thr_rdata;
    reg           v1_reg;
    reg  [PW-1:0] idx1_reg;
    reg  [SW-1:0] s1_reg;
    reg           v2_reg;
    reg  [PW-1:0] idx2_reg;
    reg  [SW-1:0] s2_reg;
    reg  [SW-1:0] bg2_reg;
    reg  [1:0]    cons2_reg;
    reg           we_next;
    reg  [MW-1:0] wdata_next;

    pxevd_ram #(.DW(MW), .AW(PW)) u_bgmem (
        .clk   (REF_CLK),
        .we    (we_next),
        .waddr (idx2_reg),
        .wdata (wdata_next),
        .raddr (PIX_INDEX),
        .rdata (bg_rdata)
    );

    // Threshold table indexed by the top five background bits
    pxevd_ram #(.DW(SW), .AW(`PXEVD_THR_AW)) u_thr (
        .clk   (REF_CLK),
        .we    (THR_WR),
        .waddr (THR_ADDR),
        .wdata (THR_DATA),
        .raddr (bg_rdata[SW-1:SW-5]),
        .rdata (thr_rdata)
    );

    always @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            v1_reg    <= 1'b0;
            idx1_reg  <= {PW{1'b0}};
            s1_reg    <= {SW{1'b0}};
            v2_reg    <= 1'b0;
            idx2_reg  <= {PW{1'b0}};
            s2_reg    <= {SW{1'b0}};
            bg2_reg   <= {SW{1'b0}};
            cons2_reg <= 2'h0;
            BG_VALID  <= 1'b0;
            BG_INDEX  <= {PW{1'b0}};
            BG_DATA   <= {SW{1'b0}};
        end
        else
        begin
            v1_reg    <= PIX_VALID;
            idx1_reg  <= PIX_INDEX;
            s1_reg    <= PIX_DATA;
            v2_reg    <= v1_reg;
            idx2_reg  <= idx1_reg;
            s2_reg    <= s1_reg;
            bg2_reg   <= bg_rdata[SW-1:0];
            cons2_reg <= bg_rdata[MW-1:SW];
            // Stored average, never the raw sample, goes out on a dump
            BG_VALID  <= v1_reg && dump_reg;
            BG_INDEX  <= idx1_reg;
            BG_DATA   <= bg_rdata[SW-1:0];
        end
    end

    // ********************************
    // Stage 2: detect and update average
    // ********************************
    wire signed [SW+1:0] diff = $signed({2'b00, s2_reg}) - $signed({2'b00, bg2_reg});
    wire signed [SW+1:0] step = diff >>> BG_SHIFT;
    wire signed [SW+1:0] avg  = $signed({2'b00, bg2_reg}) + step;
    // Signed compare keeps negative changes from ever firing
    wire                 hit  = v2_reg && (diff > $signed({2'b00, thr_rdata}));
    reg  [SW-1:0]        avg_sat;
    reg  [1:0]           cons_next;

    always @*
    begin
        // Shift only shrinks the step, but clamp in case of misuse
        if (avg < 0)
            avg_sat = {SW{1'b0}};
        else if (avg > $signed({2'b00, `PXEVD_BG_MAX}))
            avg_sat = `PXEVD_BG_MAX;
        else
            avg_sat = avg[SW-1:0];
        if (!hit)
            cons_next = 2'h0;
        else if (cons2_reg == 2'h3)
            cons_next = 2'h3;
        else
            cons_next = cons2_reg + 2'h1;
        we_next    = v2_reg;
        wdata_next = {cons_next, avg_sat};
    end

    // ********************************
    // Event record and queue
    // ********************************
    reg  [FIFO_AW-1:0] wp_reg;
    reg  [FIFO_AW-1:0] rp_reg;
    reg  [FIFO_AW:0]   cnt_reg;
    reg                pend_reg;
    wire [`PXEVD_REC_W-1:0] fifo_rdata;
    wire               full  = (cnt_reg == FD[FIFO_AW:0]);
    wire               push  = hit && !full;
    wire               pop   = (cnt_reg != {(FIFO_AW+1){1'b0}}) && !pend_reg
                               && (!EVT_VALID || EVT_READY);
    wire [6:0]         dev_status = {EVT_DROPPED, dump_reg, full, 4'h0};
    wire [`PXEVD_REC_W-1:0] record;

    // Record fields from bit 63 down to bit 0
    assign record = {bg2_reg[SW-1:SW-5],
                     diff[SW-1:0],
                     idx2_reg,
                     PROC_ID,
                     UNIT_ID,
                     frame_reg,
                     cons2_reg,
                     2'h0,
                     dev_status,
                     PKT_ID};

    pxevd_ram #(.DW(`PXEVD_REC_W), .AW(FIFO_AW)) u_evq (
        .clk   (REF_CLK),
        .we    (push),
        .waddr (wp_reg),
        .wdata (record),
        .raddr (rp_reg),
        .rdata (fifo_rdata)
    );

    always @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            wp_reg      <= {FIFO_AW{1'b0}};
            rp_reg      <= {FIFO_AW{1'b0}};
            cnt_reg     <= {(FIFO_AW+1){1'b0}};
            pend_reg    <= 1'b0;
            EVT_VALID   <= 1'b0;
            EVT_DATA    <= {`PXEVD_REC_W{1'b0}};
            EVT_DROPPED <= 1'b0;
        end
        else
        begin
            if (push)
                wp_reg <= wp_reg + 1'b1;
            if (pop)
                rp_reg <= rp_reg + 1'b1;
            case ({push, pop})
                2'b10:   cnt_reg <= cnt_reg + 1'b1;
                2'b01:   cnt_reg <= cnt_reg - 1'b1;
                default: cnt_reg <= cnt_reg;
            endcase
            pend_reg <= pop;
            // Only event records leave; raw samples never do
            if (pend_reg)
            begin
                EVT_VALID <= 1'b1;
                EVT_DATA  <= fifo_rdata;
            end
            else if (EVT_READY)
            begin
                EVT_VALID <= 1'b0;
            end
            // Video cannot stall, so a full queue loses the event
            if (hit && full)
                EVT_DROPPED <= 1'b1;
        end
    end
endmodule

/* File: tb/pxevd_chk_props.sv */
// Port-level assertions for the pixel event detector.
// Assumes REF_CLK with active high RST is the only domain.
`timescale 1ns/1ps
module pxevd_chk #(
    parameter [2:0] PKT_ID  = 3'h1,
    parameter [3:0] UNIT_ID = 4'h0,
    parameter [1:0] PROC_ID = 2'h0
) (
    // Clock and reset
    input wire        REF_CLK,
    input wire        RST,
    // Watched ports
    input wire        PIX_VALID,
    input wire [14:0] PIX_INDEX,
    input wire        EVT_VALID,
    input wire        EVT_READY,
    input wire [63:0] EVT_DATA,
    input wire        EVT_DROPPED,
    input wire        BG_VALID,
    input wire [14:0] BG_INDEX
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);
    a_evt_hold_stable: assert property (
        EVT_VALID && !EVT_READY |=> EVT_VALID && $stable(EVT_DATA)) else $error("record moved");
    a_take_gap: assert property (
        EVT_VALID && EVT_READY |=> !EVT_VALID) else $error("no gap after take");
    a_zero_fill: assert property (
        EVT_VALID |-> EVT_DATA[11:10] == 2'h0 && EVT_DATA[6:3] == 4'h0) else $error("fill");
    a_id_fields: assert property (
        EVT_VALID |-> EVT_DATA[2:0] == PKT_ID && EVT_DATA[27:24] == UNIT_ID
        && EVT_DATA[29:28] == PROC_ID) else $error("id fields");
    a_pix_range: assert property (
        EVT_VALID |-> EVT_DATA[44:30] < 15'h7c6a) else $error("pixel index range");
    a_pos_excess: assert property (
        EVT_VALID |-> EVT_DATA[58:45] != 14'h0) else $error("zero intensity");
    a_drop_sticky: assert property (
        EVT_DROPPED |=> EVT_DROPPED) else $error("drop flag cleared");
    a_dump_source: assert property (
        BG_VALID |-> $past(PIX_VALID, 2) && BG_INDEX == $past(PIX_INDEX, 2))
        else $error("dump without sample");
endmodule
bind pxevd_top pxevd_chk #(.PKT_ID(PKT_ID), .UNIT_ID(UNIT_ID), .PROC_ID(PROC_ID)) u_chk (
    .REF_CLK, .RST, .PIX_VALID, .PIX_INDEX, .EVT_VALID, .EVT_READY, .EVT_DATA,
    .EVT_DROPPED, .BG_VALID, .BG_INDEX);

/* File: tb/pxevd_fmt_model.sv */
// Formatter-side sink: takes event records in order into a queue.
// Assumes a valid/ready record stream on clk.
`timescale 1ns/1ps
module pxevd_fmt_model (
    // Clock and reset
    input  wire        clk,
    input  wire        rst,
    // Pacing
    input  wire        stall,
    input  wire        slow,
    // Records
    input  wire        evt_valid,
    input  wire [63:0] evt_data,
    output reg         evt_ready
);
    logic [63:0] recs[$];
    always @(posedge clk or posedge rst)
    begin
        if (rst)
            evt_ready <= 1'b0;
        else
        begin
            if (evt_valid && evt_ready)
                recs.push_back(evt_data);
            // Slow pacing drops ready every other cycle to stress the hold
            evt_ready <= !stall && !(slow && evt_ready);
        end
    end
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the pixel event detector.
// Assumes the design, its header and the formatter model are compiled.
`timescale 1ns/1ps
`include "pxevd_regs.vh"
module tb_top;
    reg         ref_clk = 1'b0, rst = 1'b1, fs = 1'b0, pv = 1'b0;
    reg         thr_wr = 1'b0, stall = 1'b0, slow = 1'b0;
    reg  [14:0] pi = 15'h0;
    reg  [13:0] pd = 14'h0, thr_data = 14'h0;
    reg  [4:0]  thr_addr = 5'h0;
    reg  [3:0]  bg_shift = 4'h0;
    wire        evt_valid, evt_ready, evt_dropped, bg_valid;
    wire [63:0] evt_data;
    wire [14:0] bg_index;
    wire [13:0] bg_data;
    integer     miscompares = 0, samples_checked = 0, i, n;

    pxevd_top #(.DUMP_FRAMES(4)) dut (.REF_CLK(ref_clk), .RST(rst), .FRAME_START(fs),
        .PIX_VALID(pv), .PIX_INDEX(pi), .PIX_DATA(pd), .BG_SHIFT(bg_shift), .THR_WR(thr_wr),
        .THR_ADDR(thr_addr), .THR_DATA(thr_data), .EVT_VALID(evt_valid),
        .EVT_READY(evt_ready), .EVT_DATA(evt_data), .EVT_DROPPED(evt_dropped),
        .BG_VALID(bg_valid), .BG_INDEX(bg_index), .BG_DATA(bg_data));
    pxevd_fmt_model fmt (.clk(ref_clk), .rst(rst), .stall(stall), .slow(slow),
        .evt_valid(evt_valid), .evt_data(evt_data), .evt_ready(evt_ready));

    initial forever #5 ref_clk = ~ref_clk;

    task complete_run;
    begin
        if (miscompares == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
    endtask

    task chk(input [63:0] exp, input [63:0] got);
    begin
        samples_checked = samples_checked + 1;
        if (got !== exp)
        begin
            $display("Error t=%0t exp=%h got=%h", $time, exp, got);
            miscompares = miscompares + 1;
        end
    end
    endtask

    function [63:0] rec(input [1:0] c, input [6:0] st, input [9:0] fr, input [14:0] px,
                        input [13:0] dif);
        rec = {5'h0, dif, px, `PXEVD_PROC_ID, `PXEVD_UNIT_ID, fr, c, 2'h0, st, `PXEVD_PKT_ID};
    endfunction

    task pix(input [14:0] p, input [13:0] d);
    begin
        pv <= 1'b1;
        pi <= p;
        pd <= d;
        @(posedge ref_clk);
        pv <= 1'b0;
        @(posedge ref_clk);
    end
    endtask

    task frm;
    begin
        fs <= 1'b1;
        @(posedge ref_clk);
        fs <= 1'b0;
        @(posedge ref_clk);
    end
    endtask

    task next_rec(input [63:0] exp);
    begin
        n = 0;
        while (fmt.recs.size() == 0 && n < 60)
        begin
            @(posedge ref_clk);
            n = n + 1;
        end
        chk(exp, (fmt.recs.size() == 0) ? 64'h0 : fmt.recs.pop_front());
    end
    endtask

    task bg_pix(input [14:0] p, input [13:0] d, input [13:0] exp);
    begin
        pix(p, d);
        n = 0;
        // The dump word stands for one cycle, starting at the edge pix returns on
        repeat (4)
        begin
            #1;
            if (bg_valid === 1'b1)
            begin
                chk({p, exp}, {bg_index, bg_data});
                n = n + 1;
            end
            @(posedge ref_clk);
        end
        chk(1, n);
        @(posedge ref_clk);
    end
    endtask

    // ****************
    // Scenarios
    // ****************
    task t_detect;
    begin
        // First pass fires on every dark pixel and loads the averages, second pass clears the consecutive counts
        for (n = 0; n < 2; n = n + 1)
        begin
            frm;
            for (i = 0; i < 30; i = i + 1)
                pix(i[14:0], (i == 2) ? 14'h0600 : 14'h0100);
        end
        repeat (20) @(posedge ref_clk);
        fmt.recs.delete();
        slow <= 1'b1;
        frm;
        pix(15'h0, 14'h0110);
        pix(15'h1, 14'h0111);
        pix(15'h2, 14'h0613);
        pix(15'h3, 14'h00f0);
        next_rec(rec(2'h0, 7'h00, 10'h3, 15'h1, 14'h0011));
        repeat (30) @(posedge ref_clk);
        chk(0, fmt.recs.size());
    end
    endtask

    task t_dump;
    begin
        frm;
        bg_pix(15'h0, 14'h0110, 14'h0110);
        bg_pix(15'h1, 14'h0122, 14'h0111);
        // Half steps: 0x100 toward 0x300 gives 0x200, then toward 0x100 gives 0x180
        bg_shift <= 4'h1;
        bg_pix(15'h5, 14'h0300, 14'h0100);
        bg_pix(15'h5, 14'h0100, 14'h0200);
        bg_pix(15'h5, 14'h0180, 14'h0180);
        next_rec(rec(2'h1, 7'h20, 10'h4, 15'h1, 14'h0011));
        next_rec(rec(2'h0, 7'h20, 10'h4, 15'h5, 14'h0200));
    end
    endtask

    task t_drop;
    begin
        frm;
        stall <= 1'b1;
        chk(0, evt_dropped);
        for (i = 3; i < 30; i = i + 1)
            pix(i[14:0], 14'h0200);
        repeat (10) @(posedge ref_clk);
        chk(1, evt_dropped);
        stall <= 1'b0;
        slow <= 1'b0;
        repeat (200) @(posedge ref_clk);
        n = fmt.recs.size();
        chk((1 << `PXEVD_FIFO_AW) + 1, n);
        chk(15'h3, (n > 0) ? fmt.recs[0][44:30] : 15'h0);
    end
    endtask

    initial
    begin
        // Background memory powers up unknown and never recovers; start dark
        for (i = 0; i < 32768; i = i + 1)
            dut.u_bgmem.mem[i] = 16'h0;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        for (i = 0; i < 32; i = i + 1)
        begin
            thr_wr <= 1'b1;
            thr_addr <= i[4:0];
            thr_data <= 14'h0010 + i[13:0];
            @(posedge ref_clk);
        end
        thr_wr <= 1'b0;
        t_detect;
        t_dump;
        t_drop;
        complete_run;
    end

    initial
    begin
        #50000;
        miscompares = miscompares + 1;
        complete_run;
    end
endmodule
